// ### core/ppfs_pkg.sv
package ppfs_pkg;

  // ****************************************
  // Widths and pin positions
  // ****************************************
  localparam int unsigned P0_W = 4;
  localparam int unsigned P1_W = 5;
  localparam int unsigned IN_W = 10;
  localparam int unsigned P0_TXD = 0;
  localparam int unsigned P0_RXD = 1;
  localparam int unsigned P0_SCK = 2;
  localparam int unsigned P0_BUZ = 3;
  localparam int unsigned P1_RMT = 0;
  localparam int unsigned P1_T7O = 1;
  localparam int unsigned P1_T2 = 2;
  localparam int unsigned P1_T3 = 3;
  localparam int unsigned P1_T7IO = 4;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_P0_DATA = 8'h00;
  localparam logic [7:0] ADDR_P0_DIR = 8'h04;
  localparam logic [7:0] ADDR_P0_PLU = 8'h08;
  localparam logic [7:0] ADDR_P0_ODRAIN = 8'h0c;
  localparam logic [7:0] ADDR_P1_DATA = 8'h10;
  localparam logic [7:0] ADDR_P1_DIR = 8'h14;
  localparam logic [7:0] ADDR_P1_PLU = 8'h18;
  localparam logic [7:0] ADDR_P1_OMD = 8'h1c;
  localparam logic [7:0] ADDR_PC_DATA = 8'h20;
  localparam logic [7:0] ADDR_PC_DIR = 8'h24;
  localparam logic [7:0] ADDR_PC_PLU = 8'h28;
  localparam logic [7:0] ADDR_SER_MODE1 = 8'h2c;
  localparam logic [7:0] ADDR_CARRIER = 8'h30;
  localparam logic [7:0] ADDR_DELAY = 8'h34;
  localparam logic [7:0] ADDR_P0_IN = 8'h38;
  localparam logic [7:0] ADDR_P1_IN = 8'h3c;
  localparam logic [7:0] ADDR_PC_IN = 8'h40;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [P1_W-1:0] P1_DIR_RST = 5'h01;
  localparam logic [P0_W-1:0] P0_OD_MASK = 4'h5;
  localparam int unsigned SM_TX_EN = 0;
  localparam int unsigned SM_RX_EN = 1;
  localparam int unsigned SM_CLK_OUT = 2;
  localparam int unsigned SM_UART = 3;
  localparam int unsigned CC_CARRIER = 0;
  localparam int unsigned CC_T7 = 1;
  localparam int unsigned DC_BUZ_EN = 3;

  // ****************************************
  // Buzzer divider
  // ****************************************
  localparam int unsigned BUZ_TAP_BASE = 10;
  localparam int unsigned BUZ_CNT_W = 18;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } ppfs_pad_t;

endpackage

// ### core/ppfs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### core/ppfs_buzzer.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_buzzer
  import ppfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [2:0] freq_sel,
  output logic tone
);
  logic [BUZ_CNT_W-1:0] cnt_q;
  logic tap_q;
  logic tap;
  logic tick;

  assign tap = cnt_q[BUZ_TAP_BASE + 32'(freq_sel)];
  // One-cycle enable pulse on each rising tap edge
  assign tick = tap & ~tap_q;

  always_ff @(posedge clk)
  begin
    if (rst || !enable)
    begin
      cnt_q <= '0;
      tap_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tap_q <= tap;
    end
  end

  // Idle low so a disabled buzzer draws no current
  always_ff @(posedge clk)
  begin
    if (rst || !enable)
      tone <= 1'b0;
    else if (tick)
      tone <= ~tone;
  end
endmodule
`default_nettype wire

// ### core/ppfs_pin_mux.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_mux
  import ppfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [P0_W-1:0] port0_pin_in,
  output ppfs_pad_t [P0_W-1:0] port0_pad,
  input wire logic [P1_W-1:0] port1_pin_in,
  output ppfs_pad_t [P1_W-1:0] port1_pad,
  input wire logic portc_pin_in,
  output ppfs_pad_t portc_pad,
  input wire logic serial_tx_data,
  input wire logic serial_clk_out,
  output logic serial_rx_data,
  output logic serial_clk_in,
  output logic serial_uart_mode,
  input wire logic timer2_out,
  input wire logic timer3_out,
  input wire logic timer7_out,
  input wire logic timer7_pwm,
  input wire logic timer7_io_out,
  input wire logic carrier_signal,
  output logic timer2_evt,
  output logic timer3_evt,
  output logic timer7_evt
);

  // ****************************************
  // Register state
  // ****************************************
  logic [P0_W-1:0] port0_data_q;
  logic [P0_W-1:0] port0_direction_q;
  logic [P0_W-1:0] port0_pullup_select_q;
  logic [P0_W-1:0] port0_odrain_q;
  logic [P1_W-1:0] port1_data_q;
  logic [P1_W-1:0] port1_direction_q;
  logic [P1_W-1:0] port1_pullup_select_q;
  logic [P1_W-1:0] port1_output_mode_q;
  logic portc_data_q;
  logic portc_direction_q;
  logic portc_pullup_select_q;
  logic [3:0] serial_mode_register_1_q;
  logic [1:0] carrier_output_control_q;
  logic [3:0] delay_control_setting_q;
  logic [31:0] prdata_q;
  logic slverr_q;

  logic setup;
  logic wr_en;
  logic [31:0] rd_d;
  logic err_d;
  logic [IN_W-1:0] pins_sync;
  logic [P0_W-1:0] p0_in;
  logic [P1_W-1:0] p1_in;
  logic pc_in;
  logic buzz_tone;

  // ****************************************
  // Pad drive helper
  // ****************************************
  // Open drain only pulls low; a high level is left to the pull-up
  function automatic ppfs_pad_t pad_drive(input logic dir, input logic val, input logic od,
                                          input logic pu);
    ppfs_pad_t p;
    p.pu = pu;
    p.out = od ? 1'b0 : val;
    p.oe = dir & (od ? ~val : 1'b1);
    return p;
  endfunction

  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] off);
    return en && (a == off);
  endfunction

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait states; read data is caught in the setup cycle
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign pready = penable;
  assign prdata = prdata_q;
  assign pslverr = slverr_q;

  always_comb
  begin
    rd_d = '0;
    err_d = 1'b0;
    unique case (paddr)
      ADDR_P0_DATA: rd_d[P0_W-1:0] = port0_data_q;
      ADDR_P0_DIR: rd_d[P0_W-1:0] = port0_direction_q;
      ADDR_P0_PLU: rd_d[P0_W-1:0] = port0_pullup_select_q;
      ADDR_P0_ODRAIN: rd_d[P0_W-1:0] = port0_odrain_q;
      ADDR_P1_DATA: rd_d[P1_W-1:0] = port1_data_q;
      ADDR_P1_DIR: rd_d[P1_W-1:0] = port1_direction_q;
      ADDR_P1_PLU: rd_d[P1_W-1:0] = port1_pullup_select_q;
      ADDR_P1_OMD: rd_d[P1_W-1:0] = port1_output_mode_q;
      ADDR_PC_DATA: rd_d[0] = portc_data_q;
      ADDR_PC_DIR: rd_d[0] = portc_direction_q;
      ADDR_PC_PLU: rd_d[0] = portc_pullup_select_q;
      ADDR_SER_MODE1: rd_d[3:0] = serial_mode_register_1_q;
      ADDR_CARRIER: rd_d[1:0] = carrier_output_control_q;
      ADDR_DELAY: rd_d[3:0] = delay_control_setting_q;
      ADDR_P0_IN: rd_d[P0_W-1:0] = p0_in;
      ADDR_P1_IN: rd_d[P1_W-1:0] = p1_in;
      ADDR_PC_IN: rd_d[0] = pc_in;
      default: err_d = 1'b1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      slverr_q <= err_d;
    end
  end

  // ****************************************
  // Port 0 registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port0_data_q <= '0;
      port0_direction_q <= '0;
      port0_pullup_select_q <= '0;
      port0_odrain_q <= '0;
    end
    else
    begin
      if (wr_hit(wr_en, paddr, ADDR_P0_DATA))
        port0_data_q <= pwdata[P0_W-1:0];
      if (wr_hit(wr_en, paddr, ADDR_P0_DIR))
        port0_direction_q <= pwdata[P0_W-1:0];
      if (wr_hit(wr_en, paddr, ADDR_P0_PLU))
        port0_pullup_select_q <= pwdata[P0_W-1:0];
      // Only the transmit and clock pins have a selectable structure
      if (wr_hit(wr_en, paddr, ADDR_P0_ODRAIN))
        port0_odrain_q <= pwdata[P0_W-1:0] & P0_OD_MASK;
    end
  end

  // ****************************************
  // Port 1 registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port1_data_q <= '0;
      port1_direction_q <= P1_DIR_RST;
      port1_pullup_select_q <= '0;
      port1_output_mode_q <= '0;
    end
    else
    begin
      if (wr_hit(wr_en, paddr, ADDR_P1_DATA))
        port1_data_q <= pwdata[P1_W-1:0];
      if (wr_hit(wr_en, paddr, ADDR_P1_DIR))
        port1_direction_q <= pwdata[P1_W-1:0];
      if (wr_hit(wr_en, paddr, ADDR_P1_PLU))
        port1_pullup_select_q <= pwdata[P1_W-1:0];
      if (wr_hit(wr_en, paddr, ADDR_P1_OMD))
        port1_output_mode_q <= pwdata[P1_W-1:0];
    end
  end

  // ****************************************
  // Port C registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      portc_data_q <= 1'b0;
      portc_direction_q <= 1'b0;
      portc_pullup_select_q <= 1'b0;
    end
    else
    begin
      if (wr_hit(wr_en, paddr, ADDR_PC_DATA))
        portc_data_q <= pwdata[0];
      if (wr_hit(wr_en, paddr, ADDR_PC_DIR))
        portc_direction_q <= pwdata[0];
      if (wr_hit(wr_en, paddr, ADDR_PC_PLU))
        portc_pullup_select_q <= pwdata[0];
    end
  end

  // ****************************************
  // Function control registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_mode_register_1_q <= '0;
      carrier_output_control_q <= '0;
      delay_control_setting_q <= '0;
    end
    else
    begin
      if (wr_hit(wr_en, paddr, ADDR_SER_MODE1))
        serial_mode_register_1_q <= pwdata[3:0];
      if (wr_hit(wr_en, paddr, ADDR_CARRIER))
        carrier_output_control_q <= pwdata[1:0];
      if (wr_hit(wr_en, paddr, ADDR_DELAY))
        delay_control_setting_q <= pwdata[3:0];
    end
  end

  // ****************************************
  // Pin input synchronisers and buzzer
  // ****************************************
  ppfs_sync #(
    .W(IN_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({portc_pin_in, port1_pin_in, port0_pin_in}),
    .q(pins_sync)
  );

  assign p0_in = pins_sync[P0_W-1:0];
  assign p1_in = pins_sync[P0_W+P1_W-1:P0_W];
  assign pc_in = pins_sync[IN_W-1];

  ppfs_buzzer u_buzzer (
    .clk(clk),
    .rst(rst),
    .enable(delay_control_setting_q[DC_BUZ_EN]),
    .freq_sel(delay_control_setting_q[2:0]),
    .tone(buzz_tone)
  );

  // ****************************************
  // Output source selection
  // ****************************************
  logic ser_clk_used;
  logic [P0_W-1:0] p0_val;
  logic [P1_W-1:0] p1_val;
  ppfs_pad_t [P0_W-1:0] p0_pad_d;
  ppfs_pad_t [P1_W-1:0] p1_pad_d;
  ppfs_pad_t pc_pad_d;

  // UART needs no clock line, so the clock pin stays general I/O
  assign ser_clk_used = (serial_mode_register_1_q[SM_TX_EN] | serial_mode_register_1_q[SM_RX_EN])
                        & ~serial_mode_register_1_q[SM_UART];

  always_comb
  begin
    p0_val = port0_data_q;
    if (serial_mode_register_1_q[SM_TX_EN])
      p0_val[P0_TXD] = serial_tx_data;
    if (ser_clk_used && serial_mode_register_1_q[SM_CLK_OUT])
      p0_val[P0_SCK] = serial_clk_out;
    if (delay_control_setting_q[DC_BUZ_EN])
      p0_val[P0_BUZ] = buzz_tone;
  end

  // Timer 7 PWM takes priority over the carrier on the shared bit
  always_comb
  begin
    p1_val = port1_data_q;
    if (port1_output_mode_q[P1_RMT])
    begin
      if (carrier_output_control_q[CC_T7])
        p1_val[P1_RMT] = timer7_pwm;
      else if (carrier_output_control_q[CC_CARRIER])
        p1_val[P1_RMT] = carrier_signal;
    end
    if (port1_output_mode_q[P1_T7O])
      p1_val[P1_T7O] = timer7_out;
    if (port1_output_mode_q[P1_T2])
      p1_val[P1_T2] = timer2_out;
    if (port1_output_mode_q[P1_T3])
      p1_val[P1_T3] = timer3_out;
    if (port1_output_mode_q[P1_T7IO])
      p1_val[P1_T7IO] = timer7_io_out;
  end

  // Drive enable follows direction, so no function drives an input pin
  genvar gi;
  generate
    for (gi = 0; gi < P0_W; gi++)
    begin : g_p0
      assign p0_pad_d[gi] = pad_drive(port0_direction_q[gi], p0_val[gi], port0_odrain_q[gi],
                                      port0_pullup_select_q[gi]);
    end
    for (gi = 0; gi < P1_W; gi++)
    begin : g_p1
      assign p1_pad_d[gi] = pad_drive(port1_direction_q[gi], p1_val[gi], 1'b0,
                                      port1_pullup_select_q[gi]);
    end
  endgenerate

  assign pc_pad_d = pad_drive(portc_direction_q, portc_data_q, 1'b0, portc_pullup_select_q);

  // ****************************************
  // Registered pad outputs
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port0_pad <= '0;
      portc_pad <= '0;
      for (int i = 0; i < P1_W; i++)
      begin
        port1_pad[i].out <= 1'b0;
        port1_pad[i].oe <= P1_DIR_RST[i];
        port1_pad[i].pu <= 1'b0;
      end
    end
    else
    begin
      port0_pad <= p0_pad_d;
      port1_pad <= p1_pad_d;
      portc_pad <= pc_pad_d;
    end
  end

  // ****************************************
  // Peripheral inputs
  // ****************************************
  // Gated inputs rest at a quiet level so peripherals see no false edges
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_rx_data <= 1'b1;
      serial_clk_in <= 1'b1;
      serial_uart_mode <= 1'b0;
      timer2_evt <= 1'b0;
      timer3_evt <= 1'b0;
      timer7_evt <= 1'b0;
    end
    else
    begin
      serial_rx_data <= (serial_mode_register_1_q[SM_RX_EN] && !port0_direction_q[P0_RXD])
                        ? p0_in[P0_RXD] : 1'b1;
      serial_clk_in <= (ser_clk_used && !serial_mode_register_1_q[SM_CLK_OUT]
                        && !port0_direction_q[P0_SCK]) ? p0_in[P0_SCK] : 1'b1;
      serial_uart_mode <= serial_mode_register_1_q[SM_UART];
      timer2_evt <= !port1_direction_q[P1_T2] && p1_in[P1_T2];
      timer3_evt <= !port1_direction_q[P1_T3] && p1_in[P1_T3];
      timer7_evt <= !port1_direction_q[P1_T7IO] && p1_in[P1_T7IO];
    end
  end

endmodule
`default_nettype wire

// ### verification/ppfs_pin_mux_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_mux_asserts
  import ppfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire ppfs_pad_t [P1_W-1:0] port1_pad,
  input wire ppfs_pad_t portc_pad,
  input wire logic timer2_out,
  input wire logic timer7_out,
  input wire logic timer7_pwm,
  input wire logic carrier_signal,
  input wire logic timer2_evt
);
  // ****************************************
  // Shadow of port 1 settings
  // ****************************************
  // Kept from bus writes so pads are judged against software intent
  logic [P1_W-1:0] dat_q;
  logic [P1_W-1:0] dir_q;
  logic [P1_W-1:0] omd_q;
  logic [1:0] car_q;
  logic wr;
  assign wr = psel && penable && pwrite;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dat_q <= '0;
      dir_q <= P1_DIR_RST;
      omd_q <= '0;
      car_q <= '0;
    end
    else if (wr)
    begin
      if (paddr == ADDR_P1_DATA)
        dat_q <= pwdata[P1_W-1:0];
      if (paddr == ADDR_P1_DIR)
        dir_q <= pwdata[P1_W-1:0];
      if (paddr == ADDR_P1_OMD)
        omd_q <= pwdata[P1_W-1:0];
      if (paddr == ADDR_CARRIER)
        car_q <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************
  // Properties
  // ****************************************
  property p_pc_rst;
    $fell(rst) |-> portc_pad == '0;
  endproperty
  a_pc_rst: assert property (p_pc_rst) else $error("port c not floating after reset");
  property p_p1_rst;
    $fell(rst) |-> port1_pad[P1_RMT] == 3'b010 && port1_pad[P1_W-1:1] == '0;
  endproperty
  a_p1_rst: assert property (p_p1_rst) else $error("port 1 reset state wrong");
  property p_p1_oe;
    port1_pad[P1_T2].oe == $past(dir_q[P1_T2]) && port1_pad[P1_T3].oe == $past(dir_q[P1_T3]);
  endproperty
  a_p1_oe: assert property (p_p1_oe) else $error("timer pin enable not from direction");
  property p_t2;
    $past(omd_q[P1_T2] && dir_q[P1_T2]) |-> port1_pad[P1_T2].out == $past(timer2_out);
  endproperty
  a_t2: assert property (p_t2) else $error("timer 2 output not on pin");
  property p_t7;
    $past(omd_q[P1_T7O] && dir_q[P1_T7O]) |-> port1_pad[P1_T7O].out == $past(timer7_out);
  endproperty
  a_t7: assert property (p_t7) else $error("timer 7 output not on pin");
  property p_t7pwm;
    $past(omd_q[P1_RMT] && dir_q[P1_RMT] && car_q[CC_T7]) |-> port1_pad[P1_RMT].out == $past(timer7_pwm);
  endproperty
  a_t7pwm: assert property (p_t7pwm) else $error("pwm not on shared pin");
  property p_car;
    $past(omd_q[P1_RMT] && dir_q[P1_RMT] && car_q == 2'b01) |-> port1_pad[P1_RMT].out == $past(carrier_signal);
  endproperty
  a_car: assert property (p_car) else $error("carrier not on shared pin");
  property p_gpio;
    $past(!omd_q[P1_T3] && dir_q[P1_T3]) |-> port1_pad[P1_T3].out == $past(dat_q[P1_T3]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("data latch not on pin");
  property p_evt;
    dir_q[P1_T2] && $past(dir_q[P1_T2]) && $past(dir_q[P1_T2], 2) |-> !timer2_evt;
  endproperty
  a_evt: assert property (p_evt) else $error("event seen on output pin");
  cover property ($past(omd_q[P1_RMT] && dir_q[P1_RMT] && car_q[CC_T7]));
  cover property ($past(omd_q[P1_RMT] && dir_q[P1_RMT] && car_q == 2'b01));
  cover property ($past(!omd_q[P1_T3] && dir_q[P1_T3]));
endmodule

bind ppfs_pin_mux ppfs_pin_mux_asserts u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .port1_pad(port1_pad), .portc_pad(portc_pad),
  .timer2_out(timer2_out), .timer7_out(timer7_out), .timer7_pwm(timer7_pwm),
  .carrier_signal(carrier_signal), .timer2_evt(timer2_evt));
`default_nettype wire

// ### verification/ppfs_board.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_board
  import ppfs_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire ppfs_pad_t [W-1:0] pad,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin
);
  // Undriven line wanders so a stale level never passes
  logic flip_q = 1'b0;
  always_ff @(posedge clk)
  begin
    flip_q <= !flip_q;
  end
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (pad[i].oe)
        pin[i] = pad[i].out;
      else if (ext_en[i])
        pin[i] = ext_val[i];
      else if (pad[i].pu)
        pin[i] = 1'b1;
      else
        pin[i] = flip_q ^ i[0];
    end
  end
endmodule
`default_nettype wire

// ### verification/port_pin_function_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_select_tb
  import ppfs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [P0_W-1:0] p0_pin, e0 = '0, v0 = '0;
  logic [P1_W-1:0] p1_pin, e1 = '0, v1 = '0;
  logic pc_pin;
  ppfs_pad_t [P0_W-1:0] p0_pad;
  ppfs_pad_t [P1_W-1:0] p1_pad;
  ppfs_pad_t pc_pad;
  logic stx = 1'b0, sclko = 1'b0, t2o = 1'b0, t3o = 1'b0, t7o = 1'b0, t7p = 1'b0, t7io = 1'b0, car = 1'b0;
  logic srx, sclki, suart, t2e, t3e, t7e;
  int errors = 0;
  int comparisons = 0;

  always #10 clk = ~clk;

  ppfs_pin_mux uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin_in(p0_pin),
    .port0_pad(p0_pad), .port1_pin_in(p1_pin), .port1_pad(p1_pad), .portc_pin_in(pc_pin),
    .portc_pad(pc_pad), .serial_tx_data(stx), .serial_clk_out(sclko), .serial_rx_data(srx),
    .serial_clk_in(sclki), .serial_uart_mode(suart), .timer2_out(t2o), .timer3_out(t3o),
    .timer7_out(t7o), .timer7_pwm(t7p), .timer7_io_out(t7io), .carrier_signal(car),
    .timer2_evt(t2e), .timer3_evt(t3e), .timer7_evt(t7e));
  ppfs_board #(.W(P0_W)) b0 (.clk(clk), .pad(p0_pad), .ext_en(e0), .ext_val(v0), .pin(p0_pin));
  ppfs_board #(.W(P1_W)) b1 (.clk(clk), .pad(p1_pad), .ext_en(e1), .ext_val(v1), .pin(p1_pin));
  ppfs_board #(.W(1)) bc (.clk(clk), .pad(pc_pad), .ext_en(1'b0), .ext_val(1'b0), .pin(pc_pin));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report;
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Checks land at the falling edge, after the design's updates
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [P1_W-1:0] p1_out();
    for (int i = 0; i < P1_W; i++)
      p1_out[i] = p1_pad[i].out;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      chk("pready", 1, 0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", xe, e);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    cyc(0);
    chk("pc pad", 0, pc_pad);
    chk("p1 pad0", 3'b010, p1_pad[0]);
    chk("p1 pad4", 0, p1_pad[4]);
    rd(ADDR_P1_DIR, 32'h1, 0);
    rd(ADDR_PC_PLU, 32'h0, 0);
    rd(8'h44, 32'h0, 1);
  endtask
  task automatic t_portc;
    wr(ADDR_PC_DIR, 32'h1);
    wr(ADDR_PC_DATA, 32'h1);
    cyc(2);
    chk("pc pad", 3'b110, pc_pad);
    wr(ADDR_PC_PLU, 32'h1);
    wr(ADDR_PC_DIR, 32'h0);
    cyc(4);
    chk("pc pad", 3'b101, pc_pad);
    rd(ADDR_PC_IN, 32'h1, 0);
  endtask
  task automatic t_tx;
    @(posedge clk);
    stx <= 1'b1;
    wr(ADDR_P0_DIR, 32'h1);
    wr(ADDR_SER_MODE1, 32'h1);
    cyc(2);
    chk("tx pad", 3'b110, p0_pad[P0_TXD]);
    wr(ADDR_SER_MODE1, 32'h9);
    wr(ADDR_P0_ODRAIN, 32'h1);
    wr(ADDR_P0_PLU, 32'h1);
    cyc(2);
    chk("uart mode", 1, suart);
    chk("tx pad od", 3'b001, p0_pad[P0_TXD]);
    chk("tx pin", 1, p0_pin[P0_TXD]);
    @(posedge clk);
    stx <= 1'b0;
    cyc(2);
    chk("tx pad od", 3'b011, p0_pad[P0_TXD]);
    wr(ADDR_P0_ODRAIN, 32'h0);
    wr(ADDR_SER_MODE1, 32'h0);
    wr(ADDR_P0_DATA, 32'h1);
    cyc(2);
    chk("tx gpio", 3'b111, p0_pad[P0_TXD]);
  endtask
  task automatic t_rx;
    logic [31:0] dir [4] = '{32'h0, 32'h2, 32'h0, 32'h0};
    logic [31:0] md [4] = '{32'h2, 32'h2, 32'ha, 32'h0};
    logic x [4] = '{0, 1, 0, 1};
    @(posedge clk);
    e0[P0_RXD] <= 1'b1;
    v0[P0_RXD] <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_P0_DIR, dir[i]);
      wr(ADDR_SER_MODE1, md[i]);
      cyc(5);
      chk("rx data", x[i], srx);
    end
  endtask
  task automatic t_sclk;
    wr(ADDR_P0_DIR, 32'h4);
    wr(ADDR_SER_MODE1, 32'h5);
    @(posedge clk);
    sclko <= 1'b1;
    cyc(2);
    chk("sclk pad", 3'b110, p0_pad[P0_SCK]);
    wr(ADDR_P0_DIR, 32'h0);
    wr(ADDR_SER_MODE1, 32'h1);
    @(posedge clk);
    e0[P0_SCK] <= 1'b1;
    v0[P0_SCK] <= 1'b0;
    cyc(5);
    chk("sclk in", 0, sclki);
  endtask
  task automatic t_port1;
    wr(ADDR_P1_DIR, 32'h1f);
    wr(ADDR_P1_OMD, 32'h1f);
    wr(ADDR_CARRIER, 32'h1);
    @(posedge clk);
    {t7io, t3o, t2o, t7o, car, t7p} <= 6'b101110;
    cyc(2);
    chk("p1 out", 5'h17, p1_out());
    wr(ADDR_CARRIER, 32'h2);
    @(posedge clk);
    {t3o, t2o} <= 2'b10;
    cyc(2);
    chk("p1 pwm", 0, p1_pad[P1_RMT].out);
    chk("p1 t2t3", 2'b10, {p1_pad[3].out, p1_pad[2].out});
    wr(ADDR_P1_OMD, 32'h0);
    wr(ADDR_P1_DATA, 32'h0a);
    cyc(2);
    chk("p1 gpio", 5'h0a, p1_out());
    wr(ADDR_P1_DIR, 32'h0);
    wr(ADDR_P1_PLU, 32'h4);
    @(posedge clk);
    e1 <= 5'h18;
    v1 <= 5'h18;
    cyc(5);
    chk("p1 pu", 1, p1_pad[P1_T2].pu);
    chk("t2 evt", 1, t2e);
    chk("t3 evt", 1, t3e);
    chk("t7 evt", 1, t7e);
  endtask
  task automatic t_buzzer;
    int n;
    logic last;
    wr(ADDR_P0_DIR, 32'h8);
    // Divider restarts on each enable, so both rates start clean
    for (int f = 0; f < 2; f++)
    begin
      wr(ADDR_DELAY, 32'h8 | f);
      for (int k = 0; k < 2; k++)
      begin
        last = p0_pad[P0_BUZ].out;
        n = 0;
        while (p0_pad[P0_BUZ].out === last && n < 5000)
        begin
          @(negedge clk);
          n++;
        end
      end
      chk("buzzer half period", 2 ** (BUZ_TAP_BASE + 1 + f), n);
      wr(ADDR_DELAY, 32'h0);
    end
    cyc(3);
    chk("buzzer off", 3'b010, p0_pad[P0_BUZ]);
  endtask

  initial
  begin
    #800000;
    errors++;
    final_report();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_portc();
    t_tx();
    t_rx();
    t_sclk();
    t_port1();
    t_buzzer();
    final_report();
  end
endmodule
`default_nettype wire
